// file: logic/bram_port_regs.vh
// constants for the synchronous block memory port and its register window
// How it works
// - a read leaves the addressed stored word unchanged
// - without output register, addressed word shows on read data after the enabled edge
// - enable and write strobe high, latch reset low: addressed location takes the write data
// - write-through mode shows the newly written word on read data after the edge
// - enabled edge with latch reset loads the reset output value into the latches
// - latch reset leaves the array untouched and ignores address and write data
// - enable low: no read, no write, no latch reset on that edge
// - disabled edge keeps memory contents and output latches exactly as they were
// - with the output register selected, read data arrive one cycle later
// - output register reset loads the reset output value, gated by its clock enable
// - array reads and writes ignore the output register enable and reset
`ifndef BRAM_PORT_REGS_VH
`define BRAM_PORT_REGS_VH

// write output modes
`define WMODE_WRITE_FIRST 2'h0
`define WMODE_READ_FIRST 2'h1
`define WMODE_NO_CHANGE 2'h2

// default geometry and configuration
`define DEF_DATA_W 16
`define DEF_ADDR_W 10
`define DEF_RESET_VALUE 16'h0101
`define DEF_USE_OUTREG 1'h0

// register window
`define AXI_ADDR_W 8
`define REG_CONTROL 8'h00
`define REG_READ_COUNT 8'h04
`define REG_WRITE_COUNT 8'h08
`define REG_LRESET_COUNT 8'h0C
`define REG_CONFIG 8'h10
`define REG_LAST_ADDRESS 8'h14

// register indices
`define IDX_CONTROL 3'h0
`define IDX_READ_COUNT 3'h1
`define IDX_WRITE_COUNT 3'h2
`define IDX_LRESET_COUNT 3'h3
`define IDX_CONFIG 3'h4
`define IDX_LAST_ADDRESS 3'h5
`define IDX_NONE 3'h7

// fields
`define CTRL_CLEAR_BIT 0
`define CFG_OUTREG_BIT 2
`define COUNTER_W 32
`define EVENT_COUNT 3

// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define WORD_ZERO 32'h00000000

`endif

// file: logic/bram_array.v
// memory array with registered output latches
`include "bram_port_regs.vh"

module bram_array #(
	parameter DATA_WIDTH = `DEF_DATA_W,
	parameter ADDR_WIDTH = `DEF_ADDR_W,
	parameter [DATA_WIDTH-1:0] RESET_VALUE = `DEF_RESET_VALUE,
	parameter [1:0] WRITE_MODE = `WMODE_WRITE_FIRST
) (
	input wire clock_in,
	input wire resetn_in,
	input wire enable_in,
	input wire write_in,
	input wire latch_reset_in,
	input wire [ADDR_WIDTH-1:0] address_in,
	input wire [DATA_WIDTH-1:0] write_data_in,
	output wire [DATA_WIDTH-1:0] read_data_out
);

	reg [DATA_WIDTH-1:0] mem_q [0:(1<<ADDR_WIDTH)-1];
	reg [DATA_WIDTH-1:0] read_q;

	assign read_data_out = read_q;

	// array is written only on enabled write edges, never by latch reset
	always @(posedge clock_in) begin
		if (enable_in && write_in && !latch_reset_in) begin
			mem_q[address_in] <= write_data_in;
		end
	end

	always @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			read_q <= RESET_VALUE;
		end else if (enable_in) begin
			if (latch_reset_in) begin
				read_q <= RESET_VALUE;
			end else if (!write_in) begin
				read_q <= mem_q[address_in];
			end else begin
				case (WRITE_MODE)
					`WMODE_WRITE_FIRST: begin
						read_q <= write_data_in;
					end
					`WMODE_READ_FIRST: begin
						read_q <= mem_q[address_in];
					end
					`WMODE_NO_CHANGE: begin
						read_q <= read_q;
					end
					default: begin
						read_q <= write_data_in;
					end
				endcase
			end
		end
	end

endmodule

// file: logic/bram_port.v
// block memory port with optional output register and axi4-lite status window
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`include "bram_port_regs.vh"

module bram_port #(
	parameter DATA_WIDTH = `DEF_DATA_W,
	parameter ADDR_WIDTH = `DEF_ADDR_W,
	parameter [DATA_WIDTH-1:0] RESET_VALUE = `DEF_RESET_VALUE,
	parameter [1:0] WRITE_MODE = `WMODE_WRITE_FIRST,
	parameter [0:0] USE_OUTREG = `DEF_USE_OUTREG
) (
	input wire clock_in,
	input wire resetn_in,
	input wire port_enable_in,
	input wire write_strobe_in,
	input wire [ADDR_WIDTH-1:0] address_in,
	input wire [DATA_WIDTH-1:0] write_data_in,
	input wire latch_sync_reset_in,
	input wire outreg_sync_reset_in,
	input wire outreg_clock_enable_in,
	output wire [DATA_WIDTH-1:0] read_data_out,
	input wire [`AXI_ADDR_W-1:0] s_axi_awaddr_in,
	input wire s_axi_awvalid_in,
	output wire s_axi_awready_out,
	input wire [31:0] s_axi_wdata_in,
	input wire [3:0] s_axi_wstrb_in,
	input wire s_axi_wvalid_in,
	output wire s_axi_wready_out,
	output wire [1:0] s_axi_bresp_out,
	output wire s_axi_bvalid_out,
	input wire s_axi_bready_in,
	input wire [`AXI_ADDR_W-1:0] s_axi_araddr_in,
	input wire s_axi_arvalid_in,
	output wire s_axi_arready_out,
	output wire [31:0] s_axi_rdata_out,
	output wire [1:0] s_axi_rresp_out,
	output wire s_axi_rvalid_out,
	input wire s_axi_rready_in
);

	// maps a byte address onto a register index
	function [2:0] reg_index;
		input [`AXI_ADDR_W-1:0] addr;
		begin
			case (addr)
				`REG_CONTROL: begin
					reg_index = `IDX_CONTROL;
				end
				`REG_READ_COUNT: begin
					reg_index = `IDX_READ_COUNT;
				end
				`REG_WRITE_COUNT: begin
					reg_index = `IDX_WRITE_COUNT;
				end
				`REG_LRESET_COUNT: begin
					reg_index = `IDX_LRESET_COUNT;
				end
				`REG_CONFIG: begin
					reg_index = `IDX_CONFIG;
				end
				`REG_LAST_ADDRESS: begin
					reg_index = `IDX_LAST_ADDRESS;
				end
				default: begin
					reg_index = `IDX_NONE;
				end
			endcase
		end
	endfunction

	wire [DATA_WIDTH-1:0] latch_data;
	wire [`EVENT_COUNT-1:0] port_event;
	wire [`COUNTER_W-1:0] count_value [0:`EVENT_COUNT-1];
	wire [2:0] read_index;
	wire [2:0] write_index;
	wire [31:0] config_word;
	wire [31:0] last_address_word;
	wire both_held;

	reg clear_q;
	reg [ADDR_WIDTH-1:0] last_address_q;
	reg awready_q;
	reg wready_q;
	reg aw_held_q;
	reg w_held_q;
	reg [`AXI_ADDR_W-1:0] aw_addr_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	reg bvalid_q;
	reg [1:0] bresp_q;
	reg arready_q;
	reg rvalid_q;
	reg [31:0] rdata_q;
	reg [1:0] rresp_q;
	reg [31:0] read_word;

	// memory array and output latches; runs independent of the output register
	bram_array #(
		.DATA_WIDTH(DATA_WIDTH),
		.ADDR_WIDTH(ADDR_WIDTH),
		.RESET_VALUE(RESET_VALUE),
		.WRITE_MODE(WRITE_MODE)
	) array_inst (
		.clock_in(clock_in),
		.resetn_in(resetn_in),
		.enable_in(port_enable_in),
		.write_in(write_strobe_in),
		.latch_reset_in(latch_sync_reset_in),
		.address_in(address_in),
		.write_data_in(write_data_in),
		.read_data_out(latch_data)
	);

	// optional output pipeline register, fixed at build time
	generate
		if (USE_OUTREG) begin : with_outreg
			reg [DATA_WIDTH-1:0] outreg_q;
			always @(posedge clock_in or negedge resetn_in) begin
				if (!resetn_in) begin
					outreg_q <= RESET_VALUE;
				end else if (outreg_clock_enable_in) begin
					if (outreg_sync_reset_in) begin
						outreg_q <= RESET_VALUE;
					end else begin
						outreg_q <= latch_data;
					end
				end
			end
			assign read_data_out = outreg_q;
		end else begin : without_outreg
			assign read_data_out = latch_data;
		end
	endgenerate

	// port activity: read, write, latch reset
	assign port_event[0] = port_enable_in && !latch_sync_reset_in && !write_strobe_in;
	assign port_event[1] = port_enable_in && !latch_sync_reset_in && write_strobe_in;
	assign port_event[2] = port_enable_in && latch_sync_reset_in;

	// activity counters; an event in the clear cycle counts as one
	genvar gi;
	generate
		for (gi = 0; gi < `EVENT_COUNT; gi = gi + 1) begin : counters
			reg [`COUNTER_W-1:0] count_q;
			always @(posedge clock_in or negedge resetn_in) begin
				if (!resetn_in) begin
					count_q <= `WORD_ZERO;
				end else if (clear_q) begin
					count_q <= port_event[gi] ? 32'h00000001 : `WORD_ZERO;
				end else if (port_event[gi]) begin
					count_q <= count_q + 32'h00000001;
				end
			end
			assign count_value[gi] = count_q;
		end
	endgenerate

	// address of the last enabled edge
	always @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			last_address_q <= {ADDR_WIDTH{1'b0}};
		end else if (port_enable_in) begin
			last_address_q <= address_in;
		end
	end

	assign config_word = {29'h00000000, USE_OUTREG, WRITE_MODE};
	assign last_address_word = {{(32-ADDR_WIDTH){1'b0}}, last_address_q};
	assign read_index = reg_index(s_axi_araddr_in);
	assign write_index = reg_index(aw_addr_q);

	always @* begin
		case (read_index)
			`IDX_CONTROL: begin
				read_word = `WORD_ZERO;
			end
			`IDX_READ_COUNT: begin
				read_word = count_value[0];
			end
			`IDX_WRITE_COUNT: begin
				read_word = count_value[1];
			end
			`IDX_LRESET_COUNT: begin
				read_word = count_value[2];
			end
			`IDX_CONFIG: begin
				read_word = config_word;
			end
			`IDX_LAST_ADDRESS: begin
				read_word = last_address_word;
			end
			default: begin
				read_word = `WORD_ZERO;
			end
		endcase
	end

	// address and data both held and no response pending: answer now
	assign both_held = aw_held_q && w_held_q && !bvalid_q;

	// write address channel: taken once, held until the response is accepted
	always @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			awready_q <= 1'b1;
			aw_held_q <= 1'b0;
			aw_addr_q <= {`AXI_ADDR_W{1'b0}};
		end else begin
			if (awready_q && s_axi_awvalid_in) begin
				awready_q <= 1'b0;
				aw_held_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr_in;
			end
			if (both_held) begin
				aw_held_q <= 1'b0;
			end
			if (bvalid_q && s_axi_bready_in) begin
				awready_q <= 1'b1;
			end
		end
	end

	// write data channel: may arrive before, with or after the address
	always @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wready_q <= 1'b1;
			w_held_q <= 1'b0;
			w_data_q <= `WORD_ZERO;
			w_strb_q <= 4'h0;
		end else begin
			if (wready_q && s_axi_wvalid_in) begin
				wready_q <= 1'b0;
				w_held_q <= 1'b1;
				w_data_q <= s_axi_wdata_in;
				w_strb_q <= s_axi_wstrb_in;
			end
			if (both_held) begin
				w_held_q <= 1'b0;
			end
			if (bvalid_q && s_axi_bready_in) begin
				wready_q <= 1'b1;
			end
		end
	end

	// write response and the counter clear pulse it carries
	always @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			bvalid_q <= 1'b0;
			bresp_q <= `RESP_OKAY;
			clear_q <= 1'b0;
		end else begin
			clear_q <= 1'b0;
			if (both_held) begin
				bvalid_q <= 1'b1;
				if (write_index == `IDX_NONE) begin
					bresp_q <= `RESP_SLVERR;
				end else begin
					bresp_q <= `RESP_OKAY;
				end
				if (write_index == `IDX_CONTROL && w_strb_q[0]) begin
					clear_q <= w_data_q[`CTRL_CLEAR_BIT];
				end
			end
			if (bvalid_q && s_axi_bready_in) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// read channel: answer one cycle after the address is taken
	always @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= `WORD_ZERO;
			rresp_q <= `RESP_OKAY;
		end else begin
			if (arready_q && s_axi_arvalid_in) begin
				arready_q <= 1'b0;
				rvalid_q <= 1'b1;
				rdata_q <= read_word;
				if (read_index == `IDX_NONE) begin
					rresp_q <= `RESP_SLVERR;
				end else begin
					rresp_q <= `RESP_OKAY;
				end
			end else if (rvalid_q && s_axi_rready_in) begin
				rvalid_q <= 1'b0;
				arready_q <= 1'b1;
			end
		end
	end

	assign s_axi_awready_out = awready_q;
	assign s_axi_wready_out = wready_q;
	assign s_axi_bvalid_out = bvalid_q;
	assign s_axi_bresp_out = bresp_q;
	assign s_axi_arready_out = arready_q;
	assign s_axi_rvalid_out = rvalid_q;
	assign s_axi_rdata_out = rdata_q;
	assign s_axi_rresp_out = rresp_q;

endmodule

// file: tb/bram_port_monitor.sv
// assertions on the memory port and its register bus
module bram_port_monitor #(
	parameter DATA_WIDTH = 16,
	parameter [DATA_WIDTH-1:0] RESET_VALUE = 16'h0101,
	parameter [1:0] WRITE_MODE = 2'h0,
	parameter [0:0] USE_OUTREG = 1'h0
) (
	input wire clock_in,
	input wire resetn_in,
	input wire port_enable_in,
	input wire write_strobe_in,
	input wire latch_sync_reset_in,
	input wire [DATA_WIDTH-1:0] write_data_in,
	input wire outreg_sync_reset_in,
	input wire outreg_clock_enable_in,
	input wire [DATA_WIDTH-1:0] read_data_out,
	input wire s_axi_awvalid_in,
	input wire s_axi_awready_out,
	input wire s_axi_wvalid_in,
	input wire s_axi_wready_out,
	input wire [1:0] s_axi_bresp_out,
	input wire s_axi_bvalid_out,
	input wire s_axi_bready_in
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!resetn_in);
	AST_LRESET:
	assert property (!USE_OUTREG && port_enable_in && latch_sync_reset_in |=> read_data_out == RESET_VALUE)
		else $error("latch reset value not loaded");
	AST_LRESET_KEPT:
	assert property (!USE_OUTREG && port_enable_in && latch_sync_reset_in ##1 !port_enable_in
		|=> read_data_out == RESET_VALUE) else $error("reset value lost on disabled edge");
	AST_DISABLED:
	assert property (!USE_OUTREG && !port_enable_in |=> $stable(read_data_out))
		else $error("output moved on disabled edge");
	AST_WTHRU:
	assert property (WRITE_MODE == 2'h0 && !USE_OUTREG && port_enable_in && write_strobe_in
		&& !latch_sync_reset_in |=> read_data_out == $past(write_data_in)) else $error("write-through data missing");
	AST_NOCHG:
	assert property (WRITE_MODE == 2'h2 && !USE_OUTREG && port_enable_in && write_strobe_in
		&& !latch_sync_reset_in |=> $stable(read_data_out)) else $error("hold-output mode changed output");
	AST_OREG_RST:
	assert property (USE_OUTREG && outreg_clock_enable_in && outreg_sync_reset_in
		|=> read_data_out == RESET_VALUE) else $error("output register reset missing");
	AST_OREG_HOLD:
	assert property (USE_OUTREG && !outreg_clock_enable_in |=> $stable(read_data_out))
		else $error("output register moved while disabled");
	AST_BRESP_TIME:
	assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
		|-> ##2 s_axi_bvalid_out) else $error("write response late");
	AST_BHOLD:
	assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
		else $error("write response dropped");
endmodule

bind bram_port bram_port_monitor #(.DATA_WIDTH(DATA_WIDTH), .RESET_VALUE(RESET_VALUE),
	.WRITE_MODE(WRITE_MODE), .USE_OUTREG(USE_OUTREG)) u_mon (.clock_in(clock_in), .resetn_in(resetn_in),
	.port_enable_in(port_enable_in), .write_strobe_in(write_strobe_in), .latch_sync_reset_in(latch_sync_reset_in),
	.write_data_in(write_data_in), .outreg_sync_reset_in(outreg_sync_reset_in),
	.outreg_clock_enable_in(outreg_clock_enable_in), .read_data_out(read_data_out),
	.s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out), .s_axi_wvalid_in(s_axi_wvalid_in),
	.s_axi_wready_out(s_axi_wready_out), .s_axi_bresp_out(s_axi_bresp_out), .s_axi_bvalid_out(s_axi_bvalid_out),
	.s_axi_bready_in(s_axi_bready_in));

// file: tb/bram_fabric.sv
// user fabric model driving the memory port
module bram_fabric #(
	parameter AW = 10,
	parameter DW = 16
) (
	input wire clock_in,
	output logic en_out = 1'h0,
	output logic we_out = 1'h0,
	output logic lrst_out = 1'h0,
	output logic ors_out = 1'h0,
	output logic oce_out = 1'h0,
	output logic [AW-1:0] addr_out = '0,
	output logic [DW-1:0] data_out = '0
);
	// enable, strobes, address and data all move together; idle also moves the address
	task automatic drive(input logic w, input logic l, input logic [AW-1:0] a, input logic [DW-1:0] d);
		en_out <= 1'h1;
		we_out <= w;
		lrst_out <= l;
		addr_out <= a;
		data_out <= d;
	endtask
	// output register enable and reset, held until changed again
	task automatic outreg_ctl(input logic ce, input logic rs);
		oce_out <= ce;
		ors_out <= rs;
	endtask
	// enable low, so other inputs may move freely
	task automatic idle(input logic [AW-1:0] a, input logic [DW-1:0] d);
		en_out <= 1'h0;
		we_out <= 1'h1;
		lrst_out <= 1'h1;
		addr_out <= a;
		data_out <= d;
	endtask
endmodule

// file: tb/bram_port_tb.sv
// testbench for the block memory port
`include "bram_port_regs.vh"
module bram_port_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [15:0] RV = 16'h0101;
	logic clock_in = 1'h0;
	logic resetn_in = 1'h0;
	logic en, we, lrst, ors, oce;
	logic [9:0] addr;
	logic [15:0] wd;
	wire [15:0] rd;
	wire [15:0] rd_mode [0:2];
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [31:0] wdata = 32'h00000000;
	wire awready, wready, bvalid, arready, rvalid;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	int err_count = 0;
	int check_count = 0;
	always #50 clock_in = ~clock_in;
	bram_fabric u_fab (.clock_in(clock_in), .en_out(en), .we_out(we), .lrst_out(lrst), .ors_out(ors),
		.oce_out(oce), .addr_out(addr), .data_out(wd));
	bram_port u_dut (.clock_in(clock_in), .resetn_in(resetn_in), .port_enable_in(en), .write_strobe_in(we),
		.address_in(addr), .write_data_in(wd), .latch_sync_reset_in(lrst), .outreg_sync_reset_in(ors),
		.outreg_clock_enable_in(oce), .read_data_out(rd), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
		.s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready));
	genvar g;
	// read-first, hold-output and output register copies share the fabric inputs
	for (g = 0; g < 3; g = g + 1) begin : modes
		bram_port #(.WRITE_MODE(g == 0 ? `WMODE_READ_FIRST : g == 1 ? `WMODE_NO_CHANGE : `WMODE_WRITE_FIRST),
			.USE_OUTREG(g == 2)) u_dut (.clock_in(clock_in), .resetn_in(resetn_in), .port_enable_in(en),
			.write_strobe_in(we), .address_in(addr), .write_data_in(wd), .latch_sync_reset_in(lrst),
			.outreg_sync_reset_in(ors), .outreg_clock_enable_in(oce), .read_data_out(rd_mode[g]),
			.s_axi_awaddr_in(8'h00), .s_axi_awvalid_in(1'h0), .s_axi_awready_out(), .s_axi_wdata_in(32'h00000000),
			.s_axi_wstrb_in(4'h0), .s_axi_wvalid_in(1'h0), .s_axi_wready_out(), .s_axi_bresp_out(),
			.s_axi_bvalid_out(), .s_axi_bready_in(1'h0), .s_axi_araddr_in(8'h00), .s_axi_arvalid_in(1'h0),
			.s_axi_arready_out(), .s_axi_rdata_out(), .s_axi_rresp_out(), .s_axi_rvalid_out(), .s_axi_rready_in(1'h0));
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// one enabled op, then two disabled edges with address and data inverted and both strobes high
	task automatic op(input logic w, input logic l, input logic [9:0] a, input logic [15:0] d, input logic [15:0] e);
		u_fab.drive(w, l, a, d);
		@(posedge clock_in);
		u_fab.idle(~a, ~d);
		@(posedge clock_in);
		@(negedge clock_in);
		check(rd, e);
		@(posedge clock_in);
	endtask
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		for (n = 0; n < 50; n++) begin
			@(posedge clock_in);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
			if (bvalid) break;
		end
		bready <= 1'h0;
		if (n == 50) begin
			err_count++;
			end_sim();
		end
		check(bresp, er);
		@(posedge clock_in);
	endtask
	task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		for (n = 0; n < 50; n++) begin
			@(posedge clock_in);
			if (arready) arvalid <= 1'h0;
			if (rvalid) break;
		end
		rready <= 1'h0;
		if (n == 50) begin
			err_count++;
			end_sim();
		end
		check(rdata, ed);
		check(rresp, er);
		@(posedge clock_in);
	endtask
	task automatic t_write_read();
		op(1'h1, 1'h0, 10'h000, 16'hCCCC, 16'hCCCC);
		op(1'h1, 1'h0, 10'h3FF, 16'h5A5A, 16'h5A5A);
		op(1'h0, 1'h0, 10'h000, 16'h1234, 16'hCCCC);
		op(1'h0, 1'h0, 10'h000, 16'h0000, 16'hCCCC);
		op(1'h0, 1'h0, 10'h3FF, 16'h0000, 16'h5A5A);
	endtask
	task automatic t_lreset();
		op(1'h1, 1'h1, 10'h000, 16'hFFFF, RV);
		op(1'h0, 1'h0, 10'h000, 16'h0000, 16'hCCCC);
	endtask
	task automatic t_regs();
		axi_write(`REG_CONTROL, 32'h00000001, `RESP_OKAY);
		op(1'h1, 1'h0, 10'h155, 16'hBEEF, 16'hBEEF);
		op(1'h0, 1'h0, 10'h155, 16'h0000, 16'hBEEF);
		op(1'h0, 1'h1, 10'h2AA, 16'h0000, RV);
		axi_read(`REG_READ_COUNT, 32'h00000001, `RESP_OKAY);
		axi_read(`REG_WRITE_COUNT, 32'h00000001, `RESP_OKAY);
		axi_read(`REG_LRESET_COUNT, 32'h00000001, `RESP_OKAY);
		axi_read(`REG_LAST_ADDRESS, 32'h000002AA, `RESP_OKAY);
		axi_write(`REG_CONFIG, 32'hFFFFFFFF, `RESP_OKAY);
		axi_read(`REG_CONFIG, 32'h00000000, `RESP_OKAY);
		axi_read(`REG_CONTROL, 32'h00000000, `RESP_OKAY);
		axi_read(8'h1C, 32'h00000000, `RESP_SLVERR);
		axi_write(8'h1C, 32'h00000001, `RESP_SLVERR);
	endtask
	// write modes, output register latency, gated and enabled register reset
	task automatic t_modes();
		u_fab.outreg_ctl(1'h1, 1'h0);
		u_fab.drive(1'h1, 1'h0, 10'h000, 16'h1111);
		@(posedge clock_in);
		u_fab.idle(10'h3FF, 16'h2222);
		@(negedge clock_in);
		check(rd, 16'h1111);
		check(rd_mode[0], 16'hCCCC);
		check(rd_mode[1], RV);
		check(rd_mode[2], RV);
		@(posedge clock_in);
		@(negedge clock_in);
		check(rd_mode[2], 16'h1111);
		@(posedge clock_in);
		u_fab.outreg_ctl(1'h0, 1'h1);
		@(posedge clock_in);
		u_fab.outreg_ctl(1'h1, 1'h1);
		@(negedge clock_in);
		check(rd_mode[2], 16'h1111);
		@(posedge clock_in);
		u_fab.outreg_ctl(1'h0, 1'h0);
		u_fab.drive(1'h0, 1'h0, 10'h3FF, 16'h0000);
		@(negedge clock_in);
		check(rd_mode[2], RV);
		@(posedge clock_in);
		u_fab.outreg_ctl(1'h1, 1'h0);
		u_fab.idle(10'h000, 16'hFFFF);
		@(negedge clock_in);
		check(rd_mode[1], 16'h5A5A);
		check(rd_mode[2], RV);
		@(posedge clock_in);
		@(negedge clock_in);
		check(rd_mode[2], 16'h5A5A);
		@(posedge clock_in);
	endtask
	initial begin
		repeat (20) @(posedge clock_in);
		resetn_in <= 1'h1;
		@(posedge clock_in);
		t_write_read();
		t_lreset();
		t_regs();
		t_modes();
		end_sim();
	end
endmodule
